// ===== core/arb_pkg.sv
// Shared constants, state codes and pin carriers for the cluster bus arbiter
`default_nettype none

package arb_pkg;

	localparam int AGENTS_DEFAULT = 3;
	localparam int ID_W_DEFAULT = 2;
	localparam int SYNC_STAGES = 2;
	localparam int RESET_MASTER_ID = 0;
	localparam logic PIN_IDLE_LEVEL = 1'b1;
	localparam logic OD_DRIVE_LEVEL = 1'b0;

	typedef enum logic [4:0]
	{
		ST_IDLE = 5'h01,
		ST_REQUEST = 5'h02,
		ST_OWN = 5'h04,
		ST_YIELD = 5'h08,
		ST_HOST = 5'h10
	} agent_state_e;

	// Local transfer request from the agent's own core or DMA logic
	typedef struct packed
	{
		logic want;
		logic core;
		logic dma_high;
		logic busy;
	} xfer_req_s;

	// Everything this agent drives onto the cluster pins
	typedef struct packed
	{
		logic bus_request_n;
		logic core_priority_access_o;
		logic core_priority_access_oe;
		logic dma_priority_access_o;
		logic dma_priority_access_oe;
		logic host_bus_grant_o;
		logic host_bus_grant_oe;
		logic bus_master_flag_n;
	} pins_out_s;

	localparam pins_out_s PINS_RESET = '{
		bus_request_n: 1'b1,
		core_priority_access_o: 1'b0,
		core_priority_access_oe: 1'b0,
		dma_priority_access_o: 1'b0,
		dma_priority_access_oe: 1'b0,
		host_bus_grant_o: 1'b0,
		host_bus_grant_oe: 1'b0,
		bus_master_flag_n: 1'b1
	};

endpackage

`default_nettype wire

// ===== core/cluster_bus_arbiter.sv
// One agent's distributed arbiter for the shared cluster bus
`default_nettype none

module cluster_bus_arbiter #(
	parameter int AGENTS = arb_pkg::AGENTS_DEFAULT,
	parameter int ID_W = arb_pkg::ID_W_DEFAULT
) (
	input wire logic clk, // 50 MHz bus clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic [ID_W-1:0] agent_id, // Identity strap pins
	input wire arb_pkg::xfer_req_s xfer, // Local transfer request
	input wire logic [AGENTS-1:0] bus_request_n_in, // All agents' request pins
	input wire logic core_priority_access_n_in, // Shared core priority line
	input wire logic dma_priority_access_n_in, // Shared DMA priority line
	input wire logic host_bus_request_n_in, // Host request pin
	input wire logic host_bus_grant_n_in, // Shared host grant line
	output arb_pkg::pins_out_s pins, // Pins this agent drives
	output logic bus_owned, // Local logic may use the bus
	output logic withdrawn // Request held back by higher priority
);

	// Refuse sizes that the rotation and the pin packing cannot serve
	if (AGENTS < 2 || AGENTS > (1 << ID_W))
	begin : g_bad_agents
		$error("AGENTS must be 2 .. 2**ID_W");
	end
	// The synchronisers below are written out for exactly two stages
	if (arb_pkg::SYNC_STAGES != 2)
	begin : g_bad_sync
		$error("SYNC_STAGES must be 2");
	end

	function automatic logic is_me(input logic [ID_W-1:0] who, input logic [ID_W-1:0] me);
		is_me = (who == me);
	endfunction

	logic [ID_W-1:0] id_meta_q;
	logic [ID_W-1:0] id_sync_q;
	logic [AGENTS-1:0] br_meta_q;
	logic [AGENTS-1:0] br_sync_q;
	logic [1:0] prio_meta_q;
	logic [1:0] prio_sync_q;
	logic [1:0] host_meta_q;
	logic [1:0] host_sync_q;
	logic [ID_W-1:0] id_s;
	logic [AGENTS-1:0] br_s;
	logic cpa_s;
	logic dpa_s;
	logic hbr_s;
	logic host_owned_s;
	logic [ID_W-1:0] master_q;
	logic pick_any;
	logic [ID_W-1:0] pick_id;
	logic master_line;
	logic master_is_me;
	logic allowed;
	arb_pkg::agent_state_e state_q;
	arb_pkg::agent_state_e state_d;
	logic asking_d;
	logic request_n_q;
	logic core_oe_q;
	logic dma_oe_q;
	logic grant_oe_q;
	logic flag_n_q;

	// Every pin goes through two flops; all agents then act on identical samples.
	// Reset loads the idle level so no false edge is seen at release.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			id_meta_q <= {ID_W{arb_pkg::PIN_IDLE_LEVEL}};
			id_sync_q <= {ID_W{arb_pkg::PIN_IDLE_LEVEL}};
		end
		else
		begin
			id_meta_q <= agent_id;
			id_sync_q <= id_meta_q;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			br_meta_q <= {AGENTS{arb_pkg::PIN_IDLE_LEVEL}};
			br_sync_q <= {AGENTS{arb_pkg::PIN_IDLE_LEVEL}};
		end
		else
		begin
			br_meta_q <= bus_request_n_in;
			br_sync_q <= br_meta_q;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prio_meta_q <= {2{arb_pkg::PIN_IDLE_LEVEL}};
			prio_sync_q <= {2{arb_pkg::PIN_IDLE_LEVEL}};
		end
		else
		begin
			prio_meta_q <= {core_priority_access_n_in, dma_priority_access_n_in};
			prio_sync_q <= prio_meta_q;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			host_meta_q <= {2{arb_pkg::PIN_IDLE_LEVEL}};
			host_sync_q <= {2{arb_pkg::PIN_IDLE_LEVEL}};
		end
		else
		begin
			host_meta_q <= {host_bus_request_n_in, host_bus_grant_n_in};
			host_sync_q <= host_meta_q;
		end
	end

	assign id_s = id_sync_q;
	assign br_s = ~br_sync_q;
	assign cpa_s = ~prio_sync_q[1];
	assign dpa_s = ~prio_sync_q[0];
	assign hbr_s = ~host_sync_q[1];
	assign host_owned_s = ~host_sync_q[0];

	rotate_pick #(
		.AGENTS(AGENTS),
		.ID_W(ID_W)
	) u_pick (
		.req(br_s),
		.last(master_q),
		.any(pick_any),
		.next(pick_id)
	);

	assign master_line = br_s[master_q];
	assign master_is_me = is_me(master_q, id_s) && !host_owned_s;

	// Common view of the master: it moves only once the master's own line drops,
	// which it does only at a transaction boundary, so every agent agrees
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			master_q <= ID_W'(arb_pkg::RESET_MASTER_ID);
		else if (!host_owned_s && !master_line && pick_any)
			master_q <= pick_id;
	end

	// Who may hold a request: core beats high DMA beats normal DMA.
	// A wired line also carries our own drive, but we never test a line we drive.
	always_comb
	begin
		if (xfer.core)
			allowed = 1'b1;
		else if (xfer.dma_high)
			allowed = !cpa_s;
		else
			allowed = !cpa_s && !dpa_s;
	end

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			arb_pkg::ST_IDLE:
			begin
				if (master_is_me && !master_line && hbr_s)
					state_d = arb_pkg::ST_HOST;
				else if (xfer.want)
					state_d = allowed ? arb_pkg::ST_REQUEST : arb_pkg::ST_YIELD;
			end
			arb_pkg::ST_REQUEST:
			begin
				if (!xfer.want)
					state_d = arb_pkg::ST_IDLE;
				else if (!allowed)
					state_d = arb_pkg::ST_YIELD;
				// Host wins even when the pointer lands on us with our line already up
				else if (master_is_me && hbr_s)
					state_d = arb_pkg::ST_HOST;
				else if (master_is_me && br_s[id_s] && !hbr_s)
					state_d = arb_pkg::ST_OWN;
			end
			arb_pkg::ST_OWN:
			begin
				// Nothing changes hands in the middle of a transaction
				if (!xfer.busy)
				begin
					if (hbr_s)
						state_d = arb_pkg::ST_HOST;
					else if (!xfer.want)
						state_d = arb_pkg::ST_IDLE;
					else if (!allowed)
						state_d = arb_pkg::ST_YIELD;
				end
			end
			arb_pkg::ST_YIELD:
			begin
				if (!xfer.want)
					state_d = arb_pkg::ST_IDLE;
				else if (allowed)
					state_d = arb_pkg::ST_REQUEST;
			end
			arb_pkg::ST_HOST:
			begin
				// Request stays up the whole time so the bus comes straight back
				if (!hbr_s)
					state_d = xfer.want ? arb_pkg::ST_REQUEST : arb_pkg::ST_IDLE;
			end
			default:
				state_d = arb_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			state_q <= arb_pkg::ST_IDLE;
		else
			state_q <= state_d;
	end

	assign asking_d = (state_d == arb_pkg::ST_REQUEST) || (state_d == arb_pkg::ST_OWN);

	// Pin flops follow the next state so the pins move in the edge after the decision
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			request_n_q <= arb_pkg::PINS_RESET.bus_request_n;
		else
			request_n_q <= !(asking_d || state_d == arb_pkg::ST_HOST);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			core_oe_q <= arb_pkg::PINS_RESET.core_priority_access_oe;
		else
			core_oe_q <= asking_d && xfer.core;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			dma_oe_q <= arb_pkg::PINS_RESET.dma_priority_access_oe;
		else
			dma_oe_q <= asking_d && !xfer.core && xfer.dma_high;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			grant_oe_q <= arb_pkg::PINS_RESET.host_bus_grant_oe;
		else
			grant_oe_q <= (state_d == arb_pkg::ST_HOST);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			flag_n_q <= arb_pkg::PINS_RESET.bus_master_flag_n;
		else
			flag_n_q <= !(state_d == arb_pkg::ST_OWN);
	end

	// Open-drain data bits sit at the drive level; only the enables move the lines
	always_comb
	begin
		pins = arb_pkg::PINS_RESET;
		pins.bus_request_n = request_n_q;
		pins.core_priority_access_o = arb_pkg::OD_DRIVE_LEVEL;
		pins.core_priority_access_oe = core_oe_q;
		pins.dma_priority_access_o = arb_pkg::OD_DRIVE_LEVEL;
		pins.dma_priority_access_oe = dma_oe_q;
		pins.host_bus_grant_o = arb_pkg::OD_DRIVE_LEVEL;
		pins.host_bus_grant_oe = grant_oe_q;
		pins.bus_master_flag_n = flag_n_q;
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			bus_owned <= 1'b0;
		else
			bus_owned <= (state_d == arb_pkg::ST_OWN);
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			withdrawn <= 1'b0;
		else
			withdrawn <= (state_d == arb_pkg::ST_YIELD);
	end

endmodule

`default_nettype wire

// ===== core/rotate_pick.sv
// Round-robin picker: first requester above the last master, wrapping
`default_nettype none

module rotate_pick #(
	parameter int AGENTS = arb_pkg::AGENTS_DEFAULT,
	parameter int ID_W = arb_pkg::ID_W_DEFAULT
) (
	input wire logic [AGENTS-1:0] req, // Sampled request lines, active high
	input wire logic [ID_W-1:0] last, // Present master
	output logic any, // Some agent requests
	output logic [ID_W-1:0] next // Chosen next master
);

	always_comb
	begin
		int idx;
		idx = 0;
		any = 1'b0;
		next = last;
		// Scan last+1 upward and wrap, so last itself is tried last
		for (int k = 1; k <= AGENTS; k++)
		begin
			idx = (int'(last) + k) % AGENTS;
			if (!any && req[idx])
			begin
				any = 1'b1;
				next = ID_W'(idx);
			end
		end
	end

endmodule

`default_nettype wire

// ===== sim/cluster_bus_arbiter_asserts.sv
// Port-level properties of one arbiter agent
`default_nettype none
module cluster_bus_arbiter_asserts
(
	input wire logic clk, // Bus clock
	input wire logic nrst, // Reset, active low
	input wire arb_pkg::xfer_req_s xfer, // Local request
	input wire arb_pkg::pins_out_s pins, // Driven pins
	input wire logic bus_owned, // Owning
	input wire logic withdrawn // Held back
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_flag_owned: assert property (bus_owned == !pins.bus_master_flag_n) else $error("flag vs owned");
	a_od_low: assert property (!(pins.core_priority_access_o | pins.dma_priority_access_o | pins.host_bus_grant_o))
		else $error("open-drain level");
	a_core_req: assert property (pins.core_priority_access_oe |-> !pins.bus_request_n) else $error("core alone");
	a_dma_req: assert property (pins.dma_priority_access_oe |-> !pins.bus_request_n) else $error("dma alone");
	a_core_over_dma: assert property (!(pins.core_priority_access_oe && pins.dma_priority_access_oe))
		else $error("both priorities");
	a_grant_yield: assert property (pins.host_bus_grant_oe |-> pins.bus_master_flag_n && !pins.bus_request_n)
		else $error("grant while owning");
	a_busy_hold: assert property (bus_owned && xfer.busy |=> bus_owned) else $error("left mid transaction");
	a_withdrawn_idle: assert property (withdrawn |-> pins.bus_request_n && pins.bus_master_flag_n)
		else $error("withdrawn but requesting");
	cover property (pins.host_bus_grant_oe);
	cover property (withdrawn);
	cover property (pins.dma_priority_access_oe && bus_owned);
endmodule
bind cluster_bus_arbiter cluster_bus_arbiter_asserts u_chk (.clk(clk), .nrst(nrst), .xfer(xfer), .pins(pins),
	.bus_owned(bus_owned), .withdrawn(withdrawn));
`default_nettype wire

// ===== sim/peer_host_model.sv
// Peer agents and host around the arbiter; shared lines are pulled high
`default_nettype none
module peer_host_model #(
	parameter int AGENTS = 3
) (
	input wire arb_pkg::pins_out_s dut_pins, // Arbiter drive
	input wire logic [AGENTS-1:0] peer_want, // Peers requesting, bit 0 unused
	input wire logic peer_core, // Peers make core accesses
	input wire logic peer_dma, // Peers make high DMA
	input wire logic host_want, // Host needs the bus
	output logic [AGENTS-1:0] req_n, // All request pins
	output logic core_n, // Shared core line
	output logic dma_n, // Shared DMA line
	output logic host_req_n, // Host request
	output logic grant_n, // Shared grant line
	output logic host_owns // Host may use the bus
);
	timeunit 1ns;
	timeprecision 1ps;
	logic any;
	assign any = |peer_want[AGENTS-1:1];
	assign req_n = {~peer_want[AGENTS-1:1], dut_pins.bus_request_n};
	assign core_n = !(dut_pins.core_priority_access_oe || (peer_core && any));
	assign dma_n = !(dut_pins.dma_priority_access_oe || (peer_dma && !peer_core && any));
	assign grant_n = !dut_pins.host_bus_grant_oe;
	assign host_req_n = !host_want;
	assign host_owns = host_want && !grant_n;
endmodule
`default_nettype wire

// ===== sim/tb_cluster_bus_priority_arbitration.sv
// Self-checking bench: agent 0 among modelled peers and a host
`default_nettype none
module tb_cluster_bus_priority_arbitration;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	arb_pkg::xfer_req_s xfer = '0;
	logic [2:0] peer_want = '0;
	logic peer_core = 1'b0;
	logic peer_dma = 1'b0;
	logic host_want = 1'b0;
	arb_pkg::pins_out_s pins;
	logic bus_owned, withdrawn, core_n, dma_n, host_req_n, grant_n, host_owns;
	logic [2:0] req_n;
	int err_total = 0;
	int checks = 0;
	int cyc = 0;
	int seed = 88;
	int n;
	always #10 clk = ~clk;
	cluster_bus_arbiter #(.AGENTS(3), .ID_W(2)) DUT (.clk(clk), .nrst(nrst), .agent_id(2'h0), .xfer(xfer),
		.bus_request_n_in(req_n), .core_priority_access_n_in(core_n), .dma_priority_access_n_in(dma_n),
		.host_bus_request_n_in(host_req_n), .host_bus_grant_n_in(grant_n), .pins(pins),
		.bus_owned(bus_owned), .withdrawn(withdrawn));
	peer_host_model #(.AGENTS(3)) peers (.dut_pins(pins), .peer_want(peer_want), .peer_core(peer_core),
		.peer_dma(peer_dma), .host_want(host_want), .req_n(req_n), .core_n(core_n), .dma_n(dma_n),
		.host_req_n(host_req_n), .grant_n(grant_n), .host_owns(host_owns));
	function logic [7:0] pri(input logic core, input logic dma);
		return {6'h00, core, dma & ~core};
	endfunction
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task step(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	task wait_own(input logic v);
		n = 0;
		while (bus_owned !== v && n < 40)
		begin
			step(1);
			n++;
		end
		check(8'(bus_owned), 8'(v));
	endtask
	task wait_host;
		n = 0;
		while (!host_owns && n < 40)
		begin
			step(1);
			n++;
		end
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			complete_run();
		end
	end
	initial
	begin
		step(8);
		check(pins, arb_pkg::PINS_RESET);
		nrst = 1'b1;
		xfer = '{want: 1'b1, core: 1'b0, dma_high: 1'b1, busy: 1'b0};
		wait_own(1'b1);
		check(8'({pins.core_priority_access_oe, pins.dma_priority_access_oe}), pri(1'b0, 1'b1));
		xfer.busy = 1'b1;
		peer_want[1] = 1'b1;
		peer_core = 1'b1;
		step(3 + ($unsigned($random(seed)) % 6));
		check(8'(bus_owned), 8'h01);
		xfer.busy = 1'b0;
		wait_own(1'b0);
		check(8'({pins.bus_request_n, pins.dma_priority_access_oe, withdrawn}), 8'h05);
		peer_want[1] = 1'b0;
		peer_core = 1'b0;
		wait_own(1'b1);
		check(8'(pins.dma_priority_access_oe), 8'h01);
		xfer = '0;
		wait_own(1'b0);
		peer_want[1] = 1'b1;
		peer_dma = 1'b1;
		step(3);
		xfer.want = 1'b1;
		step(6);
		check(8'({pins.bus_request_n, withdrawn}), 8'h03);
		peer_want[1] = 1'b0;
		peer_dma = 1'b0;
		wait_own(1'b1);
		host_want = 1'b1;
		wait_host();
		check(8'({host_owns, pins.bus_master_flag_n, pins.bus_request_n}), 8'h06);
		host_want = 1'b0;
		wait_own(1'b1);
		repeat (6)
		begin
			xfer = '0;
			wait_own(1'b0);
			check(8'({pins.core_priority_access_oe, pins.dma_priority_access_oe, pins.bus_request_n}), 8'h01);
			xfer = {1'b1, 3'($random(seed)) & 3'h6};
			wait_own(1'b1);
			check(8'({pins.core_priority_access_oe, pins.dma_priority_access_oe}), pri(xfer.core, xfer.dma_high));
		end
		xfer = '0;
		wait_own(1'b0);
		peer_want = 3'h6;
		step(3);
		xfer = '{want: 1'b1, core: 1'b0, dma_high: 1'b0, busy: 1'b0};
		step(6);
		check(8'(bus_owned), 8'h00);
		peer_want[1] = 1'b0;
		host_want = 1'b1;
		step(6);
		check(8'({bus_owned, host_owns}), 8'h00);
		peer_want[2] = 1'b0;
		wait_host();
		check(8'({host_owns, pins.bus_master_flag_n, pins.bus_request_n}), 8'h06);
		host_want = 1'b0;
		wait_own(1'b1);
		complete_run();
	end
endmodule
`default_nettype wire
